/* File: common/timer3_pkg.sv */
package timer3_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_COUNT_LOW = 8'h10;
  localparam logic [7:0] IDX_PWM_CTRL = 8'h11;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h12;
  localparam logic [7:0] IDX_DUTY_LOW = 8'h13;
  localparam logic [7:0] IDX_PS_READ = 8'h14;
  localparam logic [7:0] IDX_HIGH_BITS = 8'h15;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

  // timer_pwm_control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RELOAD_BIT = 1;
  localparam int CTRL_ONESHOT_BIT = 2;
  localparam int CTRL_POL_BIT = 6;
  localparam int CTRL_OEN_BIT = 7;
  localparam logic [7:0] CTRL_RW_MASK = 8'hC7;

  // timer_clock_control fields
  localparam int CLK_SEL_LSB = 0;
  localparam int CLK_PS_DIS_BIT = 3;
  localparam int CLK_EDGE_BIT = 4;
  localparam int CLK_SRC_BIT = 5;
  localparam logic [7:0] CLK_RW_MASK = 8'h3F;

  // shared_high_bits fields
  localparam int HIGH_RELOAD_LSB = 4;
  localparam int HIGH_DUTY_LSB = 0;

  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam int IRQ_ONESHOT_BIT = 1;

  // values after reset, and the value the counter wraps to
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CLK_CTRL_RST = 8'h3F;
  localparam logic [7:0] PS_RST = 8'hFF;
  localparam logic [7:0] HIGH_RST = 8'h00;
  localparam logic [9:0] CNT_MAX = 10'h3FF;

  // pin input synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage : timer3_pkg

/* File: src/ext_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_edge_sync #(
  parameter int STAGES = 3
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // pin
  input wire logic pin_in,
  // filtered edges
  output logic rise_out,
  output logic fall_out
);
  if (STAGES < 3) begin : g_bad_stages
    $error("ext_edge_sync needs at least three stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] sh;
    logic level;
    logic rise;
    logic fall;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // level moves only once the last two stages agree
  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[STAGES-2:0], pin_in};
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    if (s_q.sh[STAGES-1] == s_q.sh[STAGES-2] &&
        s_q.sh[STAGES-1] != s_q.level) begin
      s_d.level = s_q.sh[STAGES-1];
      s_d.rise = s_q.sh[STAGES-1];
      s_d.fall = ~s_q.sh[STAGES-1];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise_out = s_q.rise;
  assign fall_out = s_q.fall;
endmodule : ext_edge_sync
`default_nettype wire

/* File: src/timer3_pwm3_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module timer3_pwm3_unit
  import timer3_pkg::*;
#(
  parameter int PS_W = 8
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // external count pin
  input wire logic external_count_pin_in,
  // pwm pad and interrupt
  output logic pwm_out,
  output logic pwm_oe_out,
  output logic irq_out
);
  if (PS_W != 8) begin : g_bad_ps
    $error("prescaler must be eight bits for the 1:256 ratio");
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] clkc;
    logic [7:0] reload_low;
    logic [7:0] high;
    logic [7:0] duty_low;
    logic [9:0] cnt;
    logic [PS_W-1:0] ps;
    logic [IRQ_W-1:0] stat;
    logic [IRQ_W-1:0] mask;
    logic pend;
    logic pend_wr;
    logic pend_hit;
    logic [7:0] pend_idx;
    logic ready;
    logic [31:0] rdata;
    logic pwm;
    logic oe;
    logic irq;
  } unit_state_t;

  unit_state_t s_q;
  unit_state_t s_d;
  logic ext_rise;
  logic ext_fall;
  logic src_tick;
  logic pre_tick;
  logic count_tick;
  logic wr_cnt;
  logic [7:0] ps_mask;
  logic [8:0] ps_span;
  logic [PS_W-1:0] ps_next;
  logic [9:0] reload_val;
  logic [9:0] duty_val;

  // pin synchroniser and edge filter
  ext_edge_sync #(
    .STAGES(SYNC_STAGES)
  ) u_ext_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .pin_in(external_count_pin_in),
    .rise_out(ext_rise),
    .fall_out(ext_fall)
  );

  // count source: instruction clock every cycle or chosen pin edge
  assign src_tick = s_q.clkc[CLK_SRC_BIT] ?
    (s_q.clkc[CLK_EDGE_BIT] ? ext_fall : ext_rise) : 1'b1;

  // prescaler tick every 2^(sel+1) source ticks, or bypassed
  assign ps_span = 9'h002 << s_q.clkc[CLK_SEL_LSB +: 3];
  assign ps_mask = 8'(ps_span - 9'h001);
  assign ps_next = s_q.ps - 8'h01;
  assign pre_tick = s_q.clkc[CLK_PS_DIS_BIT] ? src_tick :
    (src_tick && (ps_next & ps_mask) == 8'h00);
  assign count_tick = s_q.ctrl[CTRL_EN_BIT] & pre_tick;

  // bus write to the count register in this cycle
  assign wr_cnt = s_q.pend && s_q.pend_wr && s_q.pend_hit &&
    s_q.pend_idx == IDX_COUNT_LOW;

  // frame length and duty come from the reload and duty registers
  assign reload_val = {s_q.high[HIGH_RELOAD_LSB +: 2], s_q.reload_low};
  assign duty_val = {s_q.high[HIGH_DUTY_LSB +: 2], s_q.duty_low};

  // next state: prescaler, counter, bus, interrupts and pwm
  always_comb begin
    logic [IRQ_W-1:0] set;
    logic [IRQ_W-1:0] clr;
    logic active;
    logic [9:0] duty_next;
    set = '0;
    clr = '0;
    active = 1'b0;
    duty_next = 10'h000;
    s_d = s_q;

    // prescaler counts source ticks only while the timer runs
    if (s_q.ctrl[CTRL_EN_BIT] && !s_q.clkc[CLK_PS_DIS_BIT] && src_tick) begin
      s_d.ps = ps_next;
    end

    // down-counter with underflow handling per mode
    if (count_tick) begin
      if (s_q.cnt == 10'h000) begin
        if (!s_q.ctrl[CTRL_ONESHOT_BIT]) begin
          // reload select only applies in non-stop mode
          s_d.cnt = s_q.ctrl[CTRL_RELOAD_BIT] ? reload_val : CNT_MAX;
          set[IRQ_UNDERFLOW_BIT] = 1'b1;
        end
      end else begin
        s_d.cnt = s_q.cnt - 10'h001;
        if (s_q.ctrl[CTRL_ONESHOT_BIT] && s_q.cnt == 10'h001) begin
          set[IRQ_ONESHOT_BIT] = 1'b1;
        end
      end
    end

    // data phase: write or read of the latched register
    if (s_q.pend) begin
      s_d.pend = 1'b0;
      s_d.ready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (s_q.pend_hit && s_q.pend_wr) begin
        unique case (s_q.pend_idx)
          IDX_COUNT_LOW: begin
            s_d.reload_low = hwdata_in[7:0];
            s_d.cnt = {s_q.high[HIGH_RELOAD_LSB +: 2], hwdata_in[7:0]};
          end
          IDX_PWM_CTRL: s_d.ctrl = hwdata_in[7:0] & CTRL_RW_MASK;
          IDX_CLK_CTRL: s_d.clkc = hwdata_in[7:0] & CLK_RW_MASK;
          IDX_DUTY_LOW: s_d.duty_low = hwdata_in[7:0];
          IDX_HIGH_BITS: s_d.high = hwdata_in[7:0];
          IDX_IRQ_STATUS: clr = hwdata_in[IRQ_W-1:0];
          IDX_IRQ_MASK: s_d.mask = hwdata_in[IRQ_W-1:0];
          default: ;
        endcase
      end else if (s_q.pend_hit) begin
        unique case (s_q.pend_idx)
          IDX_COUNT_LOW: s_d.rdata = {24'h000000, s_q.cnt[7:0]};
          IDX_PWM_CTRL: s_d.rdata = {24'h000000, s_q.ctrl};
          IDX_CLK_CTRL: s_d.rdata = {24'h000000, s_q.clkc};
          IDX_PS_READ: s_d.rdata = {24'h000000, s_q.ps};
          IDX_HIGH_BITS: s_d.rdata = {24'h000000, s_q.high};
          IDX_IRQ_STATUS: s_d.rdata = {30'h00000000, s_q.stat};
          IDX_IRQ_MASK: s_d.rdata = {30'h00000000, s_q.mask};
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // address phase: latch a word transfer, insert one wait state
    if (hsel_in && htrans_in[1] && hready_in) begin
      s_d.pend = 1'b1;
      s_d.ready = 1'b0;
      s_d.pend_wr = hwrite_in;
      s_d.pend_idx = haddr_in[9:2];
      s_d.pend_hit = haddr_in[31:10] == 22'h000000 && hsize_in == 3'b010;
    end

    // sticky status: a new event wins over a same-cycle clear
    s_d.stat = (s_q.stat & ~clr) | set;
    s_d.irq = |(s_d.stat & s_d.mask);

    // pwm uses next count and next duty, so a duty write shows at once
    duty_next = {s_d.high[HIGH_DUTY_LSB +: 2], s_d.duty_low};
    active = s_d.cnt < duty_next;
    s_d.oe = s_d.ctrl[CTRL_OEN_BIT];
    s_d.pwm = s_d.ctrl[CTRL_OEN_BIT] &
      (active ^ s_d.ctrl[CTRL_POL_BIT]);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.clkc <= CLK_CTRL_RST;
      s_q.high <= HIGH_RST;
      s_q.ps <= PS_RST;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops, except hresp_out which is tied low
  assign hrdata_out = s_q.rdata;
  assign hreadyout_out = s_q.ready;
  assign hresp_out = 1'b0;
  assign pwm_out = s_q.pwm;
  assign pwm_oe_out = s_q.oe;
  assign irq_out = s_q.irq;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // counter steps that are not overridden by a bus write
  logic quiet_cnt;
  logic fast0;
  assign quiet_cnt = !wr_cnt;
  assign fast0 = s_q.ctrl[CTRL_EN_BIT] && !s_q.clkc[CLK_PS_DIS_BIT] &&
    !s_q.clkc[CLK_SRC_BIT] && s_q.clkc[2:0] == 3'b000 && !s_q.pend;

  sequence s_read_of(logic [7:0] idx);
    s_q.pend && !s_q.pend_wr && s_q.pend_hit && s_q.pend_idx == idx;
  endsequence

  sequence s_half_ratio;
    (pre_tick && fast0) ##1 (!pre_tick && fast0) ##1 fast0;
  endsequence

  chk_read_count: assert property (
    s_read_of(IDX_COUNT_LOW) |=> hrdata_out[7:0] == $past(s_q.cnt[7:0]) &&
      hreadyout_out) else $error("count read returned wrong byte");

  chk_count_load: assert property (
    wr_cnt |=> s_q.cnt == {$past(s_q.high[5:4]), $past(hwdata_in[7:0])})
    else $error("count write did not load ten bits");

  chk_wrap_max: assert property (
    count_tick && quiet_cnt && s_q.cnt == 10'h000 &&
    s_q.ctrl[2:1] == 2'b00 |=> s_q.cnt == CNT_MAX && s_q.stat[0])
    else $error("underflow did not wrap to max");

  chk_wrap_reload: assert property (
    count_tick && quiet_cnt && s_q.cnt == 10'h000 &&
    s_q.ctrl[2:1] == 2'b01 |=> s_q.cnt == $past(reload_val))
    else $error("underflow did not load reload value");

  chk_oneshot_stop: assert property (
    s_q.ctrl[CTRL_ONESHOT_BIT] && s_q.cnt == 10'h000 && quiet_cnt
    |=> s_q.cnt == 10'h000) else $error("one-shot kept counting");

  chk_pwm_level: assert property (
    pwm_oe_out |-> pwm_out ==
      ((s_q.cnt < duty_val) ^ s_q.ctrl[CTRL_POL_BIT]))
    else $error("pwm level wrong for count and polarity");

  chk_pad_release: assert property (
    !s_q.ctrl[CTRL_OEN_BIT] |-> !pwm_oe_out && !pwm_out)
    else $error("pwm drove pad while disabled");

  chk_prescale_ratio: assert property (
    s_half_ratio |-> pre_tick) else $error("1:2 ratio broken");

  chk_ext_edge: assert property (
    s_q.clkc[5:3] == 3'b111 && s_q.ctrl[CTRL_EN_BIT] && ext_fall &&
    quiet_cnt && s_q.cnt > 10'h001 |=> s_q.cnt == $past(s_q.cnt) - 10'h001)
    else $error("falling pin edge did not count");

  chk_src_hold: assert property (
    s_q.clkc[CLK_SRC_BIT] && !ext_rise && !ext_fall && quiet_cnt
    |=> $stable(s_q.cnt)) else $error("counted without pin edge");

  chk_ps_read: assert property (
    s_read_of(IDX_PS_READ) |=> hrdata_out[7:0] == $past(s_q.ps))
    else $error("prescaler read wrong");

  chk_freeze_off: assert property (
    !s_q.ctrl[CTRL_EN_BIT] && quiet_cnt [*2] |=> $stable(s_q.cnt))
    else $error("counter moved while disabled");

  chk_ps_bypass: assert property (
    s_q.clkc[CLK_PS_DIS_BIT] |=> s_q.ps == $past(s_q.ps))
    else $error("bypassed prescaler moved");

  chk_underflow_flag: assert property (
    count_tick && s_q.cnt == 10'h000 && !s_q.ctrl[CTRL_ONESHOT_BIT]
    |=> s_q.stat[IRQ_UNDERFLOW_BIT])
    else $error("underflow did not set its status bit");

  chk_oneshot_flag: assert property (
    count_tick && quiet_cnt && s_q.ctrl[CTRL_ONESHOT_BIT] &&
    s_q.cnt == 10'h001 |=> s_q.cnt == 10'h000 && s_q.stat[IRQ_ONESHOT_BIT])
    else $error("one-shot end not flagged");

  chk_reload_ignored: assert property (
    count_tick && quiet_cnt && s_q.cnt == 10'h000 &&
    s_q.ctrl[2:1] == 2'b11 |=> s_q.cnt == 10'h000)
    else $error("reload applied in one-shot mode");

  chk_rise_edge: assert property (
    s_q.clkc[5:3] == 3'b101 && s_q.ctrl[CTRL_EN_BIT] && ext_rise &&
    quiet_cnt && s_q.cnt > 10'h001 |=> s_q.cnt == $past(s_q.cnt) - 10'h001)
    else $error("rising pin edge did not count");

  chk_wrong_edge: assert property (
    s_q.clkc[CLK_SRC_BIT] && s_q.clkc[CLK_EDGE_BIT] && !ext_fall &&
    quiet_cnt |=> $stable(s_q.cnt)) else $error("counted on rising edge");

  chk_inst_clock: assert property (
    !s_q.clkc[CLK_SRC_BIT] && s_q.clkc[CLK_PS_DIS_BIT] &&
    s_q.ctrl[CTRL_EN_BIT] && quiet_cnt && s_q.cnt > 10'h001
    |=> s_q.cnt == $past(s_q.cnt) - 10'h001)
    else $error("instruction clock did not count every cycle");

  chk_count_step: assert property (
    count_tick && quiet_cnt && s_q.cnt != 10'h000
    |=> s_q.cnt == $past(s_q.cnt) - 10'h001)
    else $error("counter did not step by one");

  chk_ps_hold: assert property (
    !s_q.ctrl[CTRL_EN_BIT] |=> $stable(s_q.ps))
    else $error("prescaler moved while timer stopped");

  chk_ps_step: assert property (
    s_q.ctrl[CTRL_EN_BIT] && !s_q.clkc[CLK_PS_DIS_BIT] && src_tick
    |=> s_q.ps == $past(s_q.ps) - 8'h01)
    else $error("enabled prescaler did not step");

  // a status bit stays set until software writes to the status register
  chk_status_sticky: assert property (
    s_q.stat[IRQ_UNDERFLOW_BIT] && !(s_q.pend && s_q.pend_wr &&
    s_q.pend_idx == IDX_IRQ_STATUS) |=> s_q.stat[IRQ_UNDERFLOW_BIT])
    else $error("underflow status bit lost");
endmodule : timer3_pwm3_unit
`default_nettype wire

/* File: testbench/pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// external count pin source; the pin is always driven, idles at last level
module pin_model (
  // clock
  input wire logic core_clk_in,
  // pin
  output logic pin_out
);
  initial pin_out = 1'b0;
  // each step holds the level six cycles so the synchroniser settles
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (6) @(posedge core_clk_in);
      pin_out <= ~pin_out;
    end
  endtask : toggle
endmodule : pin_model
`default_nettype wire

/* File: testbench/tb_timer3_pwm3_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_timer3_pwm3_unit
  import timer3_pkg::*;
;
  logic clk, rst, hsel, hwrite, hrdy, hresp, pin, pwm, oe, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] ps0, e;
  int n_fail, tests_run, nn;
  typedef struct packed {logic w; logic [7:0] idx, wd, ex;} row_t;
  row_t rows [14];

  timer3_pwm3_unit #(.PS_W(8)) timer3_pwm3_unit_inst (
    .core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hready_in(hrdy), .hwdata_in(hwdata), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp),
    .external_count_pin_in(pin), .pwm_out(pwm), .pwm_oe_out(oe),
    .irq_out(irq));
  pin_model pin_model_inst (.core_clk_in(clk), .pin_out(pin));

  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] ex);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, ex);
    end
  endtask : check

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hrdy === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_rdy

  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] ex);
    bus(1'b0, idx, 8'h00);
    check(rd, {24'h0, ex});
  endtask : rdchk

  // n rising pin edges, then let the synchroniser drain
  task automatic edges(input int n);
    pin_model_inst.toggle(2 * n);
    repeat (10) @(posedge clk);
  endtask : edges

  // main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    n_fail = 0;
    tests_run = 0;
    rows = '{{1'b0, IDX_PWM_CTRL, 8'h00, 8'h00},
      {1'b0, IDX_CLK_CTRL, 8'h00, 8'h3F}, {1'b0, IDX_PS_READ, 8'h00, 8'hFF},
      {1'b0, IDX_DUTY_LOW, 8'h00, 8'h00}, {1'b0, IDX_IRQ_STATUS, 8'h00, 8'h00},
      {1'b0, IDX_HIGH_BITS, 8'h00, 8'h00}, {1'b1, IDX_PWM_CTRL, 8'hFE, 8'hC6},
      {1'b1, IDX_CLK_CTRL, 8'hFF, 8'h3F}, {1'b1, IDX_PS_READ, 8'h12, 8'hFF},
      {1'b1, IDX_DUTY_LOW, 8'h55, 8'h00}, {1'b1, 8'h30, 8'hAA, 8'h00},
      {1'b1, IDX_IRQ_MASK, 8'h03, 8'h03}, {1'b1, IDX_IRQ_MASK, 8'h00, 8'h00},
      {1'b1, IDX_PWM_CTRL, 8'h00, 8'h00}};
    repeat (16) @(posedge clk);
    check({27'h0, hrdy, pwm, oe, irq, hresp}, 32'h10);
    rst <= 1'b0;
    @(posedge clk);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].idx, rows[i].wd);
      rdchk(rows[i].idx, rows[i].ex);
    end
    $display("test registers done");
    wr(IDX_CLK_CTRL, 8'h28);
    wr(IDX_HIGH_BITS, 8'h10);
    wr(IDX_COUNT_LOW, 8'h23);
    edges(4);
    rdchk(IDX_COUNT_LOW, 8'h23);
    wr(IDX_PWM_CTRL, 8'h01);
    wr(IDX_IRQ_STATUS, 8'h03);
    edges(48);
    rdchk(IDX_COUNT_LOW, 8'hF3);
    rdchk(IDX_IRQ_STATUS, 8'h00);
    $display("test load done");
    wr(IDX_HIGH_BITS, 8'h00);
    wr(IDX_COUNT_LOW, 8'h02);
    edges(3);
    rdchk(IDX_COUNT_LOW, 8'hFF);
    rdchk(IDX_IRQ_STATUS, 8'h01);
    check({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdchk(IDX_IRQ_STATUS, 8'h00);
    wr(IDX_IRQ_MASK, 8'h00);
    $display("test wrap and interrupt done");
    wr(IDX_PWM_CTRL, 8'h03);
    wr(IDX_COUNT_LOW, 8'h02);
    edges(3);
    rdchk(IDX_COUNT_LOW, 8'h02);
    wr(IDX_PWM_CTRL, 8'h07);
    wr(IDX_COUNT_LOW, 8'h02);
    wr(IDX_IRQ_STATUS, 8'h03);
    edges(4);
    rdchk(IDX_COUNT_LOW, 8'h00);
    rdchk(IDX_IRQ_STATUS, 8'h02);
    $display("test reload and one-shot done");
    wr(IDX_PWM_CTRL, 8'h01);
    wr(IDX_CLK_CTRL, 8'h38);
    wr(IDX_COUNT_LOW, 8'h10);
    pin_model_inst.toggle(1);
    repeat (10) @(posedge clk);
    rdchk(IDX_COUNT_LOW, 8'h10);
    pin_model_inst.toggle(1);
    repeat (10) @(posedge clk);
    rdchk(IDX_COUNT_LOW, 8'h0F);
    $display("test edge select done");
    for (int s = 0; s < 8; s++) begin
      nn = 2 << s;
      wr(IDX_CLK_CTRL, {5'b00101, s[2:0]});
      wr(IDX_COUNT_LOW, 8'h80);
      wr(IDX_CLK_CTRL, {5'b00100, s[2:0]});
      bus(1'b0, IDX_PS_READ, 8'h00);
      ps0 = rd[7:0];
      edges(nn);
      rdchk(IDX_COUNT_LOW, 8'h7F);
      e = ps0 - nn[7:0];
      rdchk(IDX_PS_READ, e);
      wr(IDX_CLK_CTRL, {5'b00101, s[2:0]});
    end
    $display("test prescaler done");
    wr(IDX_PWM_CTRL, 8'h00);
    wr(IDX_CLK_CTRL, 8'h08);
    wr(IDX_COUNT_LOW, 8'h80);
    wr(IDX_PWM_CTRL, 8'h01);
    wr(IDX_PWM_CTRL, 8'h00);
    bus(1'b0, IDX_COUNT_LOW, 8'h00);
    e = rd[7:0];
    check({24'h0, e}, 32'h0000_007D);
    repeat (5) @(posedge clk);
    rdchk(IDX_COUNT_LOW, e);
    $display("test instruction clock done");
    wr(IDX_CLK_CTRL, 8'h00);
    bus(1'b0, IDX_PS_READ, 8'h00);
    ps0 = rd[7:0];
    wr(IDX_PWM_CTRL, 8'h01);
    repeat (8) @(posedge clk);
    wr(IDX_PWM_CTRL, 8'h00);
    rdchk(IDX_COUNT_LOW, ps0[0] ? 8'h77 : 8'h78);
    rdchk(IDX_PS_READ, ps0 - 8'h0B);
    $display("test instruction prescaler done");
    wr(IDX_HIGH_BITS, 8'h00);
    wr(IDX_DUTY_LOW, 8'h00);
    wr(IDX_COUNT_LOW, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      wr(IDX_HIGH_BITS, {7'h0, i[2]});
      wr(IDX_PWM_CTRL, {i[1], i[0], 6'h0});
      repeat (2) @(posedge clk);
      check({30'h0, oe, pwm}, {30'h0, i[1], i[1] & (i[2] ^ i[0])});
    end
    $display("test pwm done");
    print_verdict();
  end
endmodule : tb_timer3_pwm3_unit
`default_nettype wire
